// ### hw/ctor_pkg.sv
package ctor_pkg;
    localparam int ADDR_W = 12;
    localparam int VAL_W = 7;
    localparam int NUM_TIMING = 4;
    // Register indices; each register is one aligned word at 4 x index
    localparam logic [11:0] HS_ZERO_OFFSET = 12'h065;
    localparam logic [11:0] HS_TRAIL_OFFSET = 12'h066;
    localparam logic [11:0] HS_EXIT_OFFSET = 12'h067;
    localparam logic [11:0] LANE_TRANSITION_OFFSET = 12'h068;
    // Field layout
    localparam int OVERRIDE_FLAG_BIT = 7;
    localparam int VALUE_MSB = 6;
    localparam int VALUE_LSB = 0;
    // Reset values
    localparam logic OVERRIDE_FLAG_RESET = 1'b0;
    localparam logic [6:0] VALUE_RESET = 7'h00;
    // Power-down input must stay high this long before the block runs
    localparam int POWER_DOWN_SETTLE_NS = 8;
    localparam int CLK_PERIOD_NS = 4;
    localparam int POWER_DOWN_SETTLE_CYCLES =
        (POWER_DOWN_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ### hw/ctor_timing_regs.sv
`timescale 1ns/1ps
// How it works
// R1: HS-zero register, bit 7 override flag resets 0; set selects bits 6:0.
// R2: HS-trail register, bit 7 override flag resets 0; set selects bits 6:0.
// R3: HS-exit register, bit 7 override flag resets 0; set selects bits 6:0.
// R4: Lane-transition register, bit 7 override resets 0; set selects bits 6:0.
// R5: With flag clear, value field reads the automatic hardware value.
// R6: With flag set, value field is read/write; stored value resets to zero.
// R7: Power-down input is active low; block runs only while it is high.
// R8: Value writes are ignored while the register's override flag is clear.
module ctor_timing_regs (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic powerDownInput,
    input wire logic [6:0] hsZeroAuto,
    input wire logic [6:0] hsTrailAuto,
    input wire logic [6:0] hsExitAuto,
    input wire logic [6:0] laneTransitionAuto,
    output logic [6:0] hsZeroUsed,
    output logic [6:0] hsTrailUsed,
    output logic [6:0] hsExitUsed,
    output logic [6:0] laneTransitionUsed,
    output logic deviceActive
);
    import ctor_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Power-down input synchroniser and run gate

    logic pdMeta_reg;
    logic pdSync_reg;
    logic [1:0] settleCnt_reg;
    logic active_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            pdMeta_reg <= 1'b0;
            pdSync_reg <= 1'b0;
        end else begin
            pdMeta_reg <= powerDownInput;
            pdSync_reg <= pdMeta_reg;
        end
    end

    // Held low input keeps the run gate and the register bank in reset; high must persist first
    always_ff @(posedge clk) begin
        if (srst || !pdSync_reg) begin // R7
            settleCnt_reg <= 2'h0;
            active_reg <= 1'b0;
        end else if (settleCnt_reg <
                     2'(POWER_DOWN_SETTLE_CYCLES - 1)) begin
            settleCnt_reg <= settleCnt_reg + 2'h1;
        end else begin
            active_reg <= 1'b1;
        end
    end
    // The settle count is a short fixed delay; a slow supply ramp must
    // still be covered by holding the pin low from outside
    assign deviceActive = active_reg;

    ////////////////////////////////////////////////////////////////////////
    // APB decode

    logic [NUM_TIMING-1:0] hit;
    logic [NUM_TIMING-1:0][VAL_W-1:0] autoVal;
    logic [NUM_TIMING-1:0] flag_reg;
    logic [NUM_TIMING-1:0][VAL_W-1:0] value_reg;
    logic [NUM_TIMING-1:0][7:0] readVal;
    logic [ADDR_W-1:0] regIndex;
    logic addrInRange;
    logic mapped;
    logic wrStrobe;

    assign autoVal = {laneTransitionAuto, hsExitAuto, hsTrailAuto,
        hsZeroAuto};

    // Registers sit one to an aligned word: the byte address is four
    // times the register index, and the two low bits must be zero
    assign regIndex = paddr[ADDR_W+1:2];
    assign addrInRange = ~|paddr[31:ADDR_W+2] && ~|paddr[1:0];

    always_comb begin
        hit[0] = addrInRange && (regIndex == HS_ZERO_OFFSET);
        hit[1] = addrInRange && (regIndex == HS_TRAIL_OFFSET);
        hit[2] = addrInRange && (regIndex == HS_EXIT_OFFSET);
        hit[3] = addrInRange && (regIndex == LANE_TRANSITION_OFFSET);
        mapped = |hit;
    end

    // Single-cycle access phase; no wait states
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    // Byte lane 0 holds both fields, so only its strobe matters
    assign wrStrobe = psel && penable && pwrite && mapped && pstrb[0];

    ////////////////////////////////////////////////////////////////////////
    // Register storage; the flag and the value live in one byte lane

    // A low power-down pin clears the bank at the edge where it is seen,
    // so no write slips in while the run gate is still falling
    always_ff @(posedge clk) begin
        for (int i = 0; i < NUM_TIMING; i++) begin
            if (srst || !pdSync_reg || !active_reg) begin // R7
                flag_reg[i] <= OVERRIDE_FLAG_RESET; // R1 R2 R3 R4
                value_reg[i] <= VALUE_RESET; // R6
            end else if (wrStrobe && hit[i]) begin
                flag_reg[i] <= pwdata[OVERRIDE_FLAG_BIT];
                // Only an already-set flag opens the value field
                if (flag_reg[i]) begin // R8
                    value_reg[i] <= pwdata[VALUE_MSB:VALUE_LSB]; // R6
                end
            end
        end
    end

    // With the flag clear the stored value is kept but not shown
    always_comb begin
        for (int i = 0; i < NUM_TIMING; i++) begin
            readVal[i] = {flag_reg[i],
                flag_reg[i] ? value_reg[i] : autoVal[i]}; // R5
        end
    end

    assign hsZeroUsed = flag_reg[0] ? value_reg[0] : hsZeroAuto; // R1
    assign hsTrailUsed = flag_reg[1] ? value_reg[1] : hsTrailAuto; // R2
    assign hsExitUsed = flag_reg[2] ? value_reg[2] : hsExitAuto; // R3
    assign laneTransitionUsed =
        flag_reg[3] ? value_reg[3] : laneTransitionAuto; // R4

    ////////////////////////////////////////////////////////////////////////
    // Read data is registered so it holds across the access phase

    logic [31:0] rdata_next;
    always_comb begin
        rdata_next = 32'h00000000;
        for (int k = 0; k < NUM_TIMING; k++) begin
            if (hit[k]) begin
                rdata_next = {24'h000000, readVal[k]};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    // Reset and power-down
    flag_reset_a: assert property (@(posedge clk) // R1
        srst |=> flag_reg[0] == 1'b0 && value_reg[0] == 7'h00)
        else $error("hs zero flag not cleared by reset");
    bank_reset_a: assert property (@(posedge clk) // R6
        srst |=> flag_reg == 4'h0 && value_reg == 28'h0000000)
        else $error("timing bank not cleared by reset");
    power_gate_a: assert property (@(posedge clk) disable iff (srst) // R7
        !pdSync_reg |=> !active_reg ##0 flag_reg == 4'h0)
        else $error("block active while powered down");
    run_gate_a: assert property (@(posedge clk) disable iff (srst) // R7
        active_reg |-> $past(pdSync_reg))
        else $error("block running while power-down input low");
    write_gated_a: assert property (@(posedge clk) disable iff (srst) // R7
        wrStrobe && !active_reg |=> flag_reg == 4'h0)
        else $error("write accepted while block inactive");

    // Write path
    flag_write_a: assert property (@(posedge clk) disable iff (srst) // R1
        wrStrobe && hit[0] && active_reg && pdSync_reg
        |=> flag_reg[0] == $past(pwdata[OVERRIDE_FLAG_BIT]))
        else $error("hs zero flag write lost");
    value_write_a: assert property (@(posedge clk) disable iff (srst) // R6
        wrStrobe && hit[1] && flag_reg[1] && active_reg && pdSync_reg
        |=> value_reg[1] == $past(pwdata[6:0]))
        else $error("override value write lost");
    ignore_write_a: assert property (@(posedge clk) disable iff (srst) // R8
        !flag_reg[2] && active_reg && pdSync_reg
        |=> value_reg[2] == $past(value_reg[2]))
        else $error("value written while flag clear");
    strobe_gate_a: assert property (@(posedge clk) disable iff (srst) // R6
        psel && penable && pwrite && !pstrb[0] && active_reg && pdSync_reg
        |=> flag_reg == $past(flag_reg) && value_reg == $past(value_reg))
        else $error("write acted without byte lane 0 strobe");
    unmapped_write_a: assert property (@(posedge clk) disable iff (srst) // R6
        psel && penable && pwrite && !mapped && active_reg && pdSync_reg
        |=> flag_reg == $past(flag_reg) && value_reg == $past(value_reg))
        else $error("unmapped write changed the bank");

    // Values in effect and read-back
    trail_used_a: assert property (@(posedge clk) disable iff (srst) // R2
        wrStrobe && hit[1] && !pwdata[OVERRIDE_FLAG_BIT] && pdSync_reg
        |=> hsTrailUsed == hsTrailAuto)
        else $error("hs trail not automatic with flag clear");
    exit_used_a: assert property (@(posedge clk) disable iff (srst) // R3
        wrStrobe && hit[2] && flag_reg[2] && pwdata[OVERRIDE_FLAG_BIT]
        && active_reg && pdSync_reg
        |=> hsExitUsed == $past(pwdata[VALUE_MSB:VALUE_LSB]))
        else $error("hs exit override not used");
    lane_used_a: assert property (@(posedge clk) disable iff (srst) // R4
        wrStrobe && hit[3] && flag_reg[3] && pwdata[OVERRIDE_FLAG_BIT]
        && active_reg && pdSync_reg
        |=> laneTransitionUsed == $past(pwdata[VALUE_MSB:VALUE_LSB]))
        else $error("lane transition override not used");
    auto_read_a: assert property (@(posedge clk) disable iff (srst) // R5
        psel && !penable && !pwrite && hit[0] && !flag_reg[0]
        |=> prdata[6:0] == $past(hsZeroAuto))
        else $error("auto value not returned on read");
    override_read_a: assert property (@(posedge clk) disable iff (srst) // R6
        psel && !penable && !pwrite && hit[3] && flag_reg[3]
        |=> prdata == {24'h000000, 1'b1, $past(value_reg[3])})
        else $error("override value not returned on read");
endmodule

// ### verif/ctor_timing_regs_tb.sv
`timescale 1ns/1ps
module tb;
import ctor_pkg::*;
logic clk = 1'b0;
logic srst = 1'b1;
logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
logic [3:0] pstrb = 4'hF;
logic pready, pslverr, deviceActive, errSeen;
logic powerDownInput = 1'b0;
logic [6:0] autoV [4] = '{7'h11, 7'h22, 7'h33, 7'h44};
wire [3:0][6:0] used;
logic [11:0] offs [4] = '{HS_ZERO_OFFSET, HS_TRAIL_OFFSET,
    HS_EXIT_OFFSET, LANE_TRANSITION_OFFSET};
int fail_count = 0, num_checks = 0;
always #2 clk = ~clk;
ctor_timing_regs dut_u (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .powerDownInput(powerDownInput), .hsZeroAuto(autoV[0]),
    .hsTrailAuto(autoV[1]), .hsExitAuto(autoV[2]),
    .laneTransitionAuto(autoV[3]), .hsZeroUsed(used[0]),
    .hsTrailUsed(used[1]), .hsExitUsed(used[2]),
    .laneTransitionUsed(used[3]), .deviceActive(deviceActive));
////////////////////////////////////////////////////////////////////////
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
        fail_count++;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
endtask
// Each register is one aligned word at four times its index
function automatic logic [31:0] addrOf(input logic [11:0] idx);
    return {18'h00000, idx, 2'h0};
endfunction
// Entered just after a rising edge; holds the request until pready
task automatic xfer(input logic w, input logic [31:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
        @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
endtask
task automatic waitActive;
    int n;
    n = 0;
    while (deviceActive !== 1'b1 && n < 50) begin
        @(posedge clk);
        n++;
    end
    chk({31'h0, deviceActive}, 32'h1);
endtask
task automatic summarize;
    if (fail_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
endtask
////////////////////////////////////////////////////////////////////////
task automatic t_reset;
    for (int i = 0; i < 4; i++) begin
        xfer(1'b0, addrOf(offs[i]), 32'h0);
        chk(rd, {25'h0, autoV[i]});
        chk({25'h0, used[i]}, {25'h0, autoV[i]});
    end
endtask
task automatic t_override;
    logic [31:0] a;
    for (int i = 0; i < 4; i++) begin
        a = addrOf(offs[i]);
        xfer(1'b1, a, 32'h0000007F);
        xfer(1'b0, a, 32'h0);
        chk(rd, {25'h0, autoV[i]});
        xfer(1'b1, a, 32'h000000FF);
        xfer(1'b0, a, 32'h0);
        chk(rd, 32'h00000080);
        xfer(1'b1, a, 32'h00000080 + i + 5);
        xfer(1'b0, a, 32'h0);
        chk(rd, 32'h00000080 + i + 5);
        chk({25'h0, used[i]}, i + 5);
        xfer(1'b1, a, 32'h0);
        xfer(1'b0, a, 32'h0);
        chk({25'h0, used[i]}, {25'h0, autoV[i]});
        chk(rd, {25'h0, autoV[i]});
    end
endtask
task automatic t_unmapped;
    xfer(1'b1, addrOf(12'h069), 32'h000000FF);
    chk({31'h0, errSeen}, 32'h1);
    xfer(1'b0, addrOf(12'h069), 32'h0);
    chk({31'h0, errSeen}, 32'h1);
    chk(rd, 32'h0);
    // A byte address inside a mapped word is refused too
    xfer(1'b0, addrOf(offs[0]) + 32'h1, 32'h0);
    chk({31'h0, errSeen}, 32'h1);
    // Without the lane 0 strobe the flag must not be set
    pstrb <= 4'hE;
    xfer(1'b1, addrOf(offs[0]), 32'h00000080);
    pstrb <= 4'hF;
    xfer(1'b0, addrOf(offs[0]), 32'h0);
    chk(rd, {25'h0, autoV[0]});
    chk({31'h0, errSeen}, 32'h0);
endtask
// Power-down must also drop a programmed override
task automatic t_power;
    xfer(1'b1, addrOf(offs[3]), 32'h00000080);
    xfer(1'b1, addrOf(offs[3]), 32'h00000085);
    chk({25'h0, used[3]}, 32'h5);
    powerDownInput <= 1'b0;
    repeat (8) @(posedge clk);
    chk({31'h0, deviceActive}, 32'h0);
    // A write while powered down must be lost
    xfer(1'b1, addrOf(offs[0]), 32'h00000080);
    powerDownInput <= 1'b1;
    waitActive();
    xfer(1'b0, addrOf(offs[3]), 32'h0);
    chk(rd, {25'h0, autoV[3]});
    xfer(1'b0, addrOf(offs[0]), 32'h0);
    chk(rd, {25'h0, autoV[0]});
endtask
////////////////////////////////////////////////////////////////////////
initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    powerDownInput <= 1'b1;
    waitActive();
    t_reset();
    t_override();
    t_unmapped();
    t_power();
    summarize();
end
initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    summarize();
end
endmodule
